// ==== src/plw_watchdog.sv ====
/*
 * Program loop watchdog with write-once mode register, keyed restart
 * register and reset-cause flag.
 * Assumes internal_osc_clock and x1_clock tick pins from other clock
 * domains (synchronised here), and a CPU bus that honours bus_wait.
 */
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

module plw_watchdog (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire plw_pkg::plw_req_t bus_req,
	output logic [7:0]            bus_rdata,
	output logic                  bus_wait,
	input  wire logic             fixed_clock_opt,
	input  wire logic             halt_mode,
	input  wire logic             stop_mode,
	input  wire logic             internal_osc_clock,
	input  wire logic             x1_clock,
	output logic                  wdt_reset
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0]                mode_reg;
	logic                      mode_written_reg;
	logic [plw_pkg::CNT_W-1:0] count_reg;
	logic [plw_pkg::CNT_W-1:0] count_next;
	logic                      cause_reg;
	logic                      wdt_reset_reg;
	logic [2:0]                osc_sync_reg;
	logic [2:0]                x1_sync_reg;
	logic                      osc_tick;
	logic                      x1_tick;
	logic                      src_x1;
	logic                      stopped;
	logic                      paused;
	logic                      tick;
	logic                      mode_wr;
	logic                      key_wr;
	logic                      key_bit;
	logic                      violation;
	logic                      overflow;
	logic                      restart;
	logic [4:0]                exp_sel;

	localparam logic [plw_pkg::CNT_W-1:0] CNT_W_ONE = 21'h00_0001;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
		hit = (a == target);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Tick synchronisers: two flops, third flop for edge detection

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			osc_sync_reg <= 3'h0;
			x1_sync_reg  <= 3'h0;
		end else begin
			osc_sync_reg <= {osc_sync_reg[1:0], internal_osc_clock};
			x1_sync_reg  <= {x1_sync_reg[1:0], x1_clock};
		end
	end

	assign osc_tick = osc_sync_reg[1] & ~osc_sync_reg[2];
	assign x1_tick  = x1_sync_reg[1] & ~x1_sync_reg[2];

	////////////////////////////////////////////////////////////////////////////
	// Source selection and pausing

	assign src_x1  = !fixed_clock_opt && mode_reg[plw_pkg::SRC_SEL_POS];
	assign stopped = !fixed_clock_opt && mode_reg[plw_pkg::SRC_STOP_POS];
	assign paused  = !fixed_clock_opt && (halt_mode || stop_mode);
	// Fixed option ignores halt and stop entirely
	assign tick    = !stopped && !paused && (src_x1 ? x1_tick : osc_tick);

	////////////////////////////////////////////////////////////////////////////
	// Access decode

	assign mode_wr = bus_req.wr && hit(bus_req.addr, plw_pkg::ADDR_MODE);
	assign key_wr  = bus_req.wr && hit(bus_req.addr, plw_pkg::ADDR_KEY);
	// Bit access of either form (read-modify-write) to the key register
	assign key_bit = (bus_req.wr || bus_req.rd) && bus_req.bit_op
		&& hit(bus_req.addr, plw_pkg::ADDR_KEY);

	assign violation = !stopped && (
		(mode_wr && mode_written_reg)
		|| (key_wr && !bus_req.bit_op && bus_req.wdata != plw_pkg::KEY_RESTART)
		|| key_bit);

	assign restart = (key_wr && !bus_req.bit_op && bus_req.wdata == plw_pkg::KEY_RESTART)
		|| (mode_wr && !mode_written_reg && !bus_req.bit_op);

	////////////////////////////////////////////////////////////////////////////
	// Mode register, write once

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mode_reg         <= plw_pkg::MODE_RESET;
			mode_written_reg <= 1'b0;
		end else if (mode_wr && !mode_written_reg && !bus_req.bit_op) begin
			mode_reg         <= {plw_pkg::MODE_TOP_BITS, bus_req.wdata[4:0]};
			mode_written_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter and overflow

	assign exp_sel = (src_x1 ? 5'(plw_pkg::X1_EXP_BASE) : 5'(plw_pkg::OSC_EXP_BASE))
		+ {2'h0, mode_reg[2:0]};
	assign overflow = tick && (count_reg == (CNT_W_ONE << exp_sel) - CNT_W_ONE);

	always_comb begin
		count_next = count_reg;
		if (restart) begin
			count_next = '0;
		end else if (tick) begin
			count_next = count_reg + CNT_W_ONE;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	// One-cycle reset request to the reset controller
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wdt_reset_reg <= 1'b0;
		end else begin
			wdt_reset_reg <= (overflow && !restart) || violation;
		end
	end

	assign wdt_reset = wdt_reset_reg;

	////////////////////////////////////////////////////////////////////////////
	// Reset-cause flag: survives watchdog-driven resets, cleared by any write to ADDR_CAUSE outside reset unless wdt_reset_reg sets it in the same cycle

	always_ff @(posedge clock) begin
		if (wdt_reset_reg) begin
			cause_reg <= 1'b1;
		end else if (!rst_n) begin
			cause_reg <= cause_reg;
		end else if (bus_req.wr && hit(bus_req.addr, plw_pkg::ADDR_CAUSE)) begin
			cause_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data and wait

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bus_rdata <= 8'h00;
		end else if (bus_req.rd) begin
			if (hit(bus_req.addr, plw_pkg::ADDR_MODE)) begin
				bus_rdata <= mode_reg;
			end else if (hit(bus_req.addr, plw_pkg::ADDR_KEY)) begin
				bus_rdata <= plw_pkg::KEY_READ;
			end else if (hit(bus_req.addr, plw_pkg::ADDR_CAUSE)) begin
				bus_rdata <= 8'(cause_reg) << plw_pkg::CAUSE_POS;
			end else begin
				bus_rdata <= 8'h00;
			end
		end else begin
			bus_rdata <= 8'h00;
		end
	end

	assign bus_wait = mode_wr;

endmodule

// ==== src/plw_pkg.sv ====
/*
 * Package for the program loop watchdog: register offsets, field layout,
 * reset values, key values and interval constants.
 * Assumes a byte-wide register port with 16-bit addresses.
 */
package plw_pkg;

	localparam logic [15:0] ADDR_MODE     = 16'hff98;
	localparam logic [15:0] ADDR_KEY      = 16'hff99;
	localparam logic [15:0] ADDR_CAUSE    = 16'hff9a;

	localparam logic [7:0]  MODE_RESET    = 8'h67;
	localparam logic [2:0]  MODE_TOP_BITS = 3'h3;
	localparam logic [7:0]  KEY_READ      = 8'h9a;
	localparam logic [7:0]  KEY_RESTART   = 8'hac;

	localparam int          SRC_STOP_POS  = 4;
	localparam int          SRC_SEL_POS   = 3;
	localparam int          CAUSE_POS     = 4;

	localparam int          OSC_EXP_BASE  = 11;
	localparam int          X1_EXP_BASE   = 13;
	localparam int          CNT_W         = 21;

	// Bus request bundle
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
		logic        bit_op;
	} plw_req_t;

endpackage

// ==== bench/plw_watchdog_sva.sv ====
/* Port checker for the program loop watchdog.
   Assumes the bench holds rst_n low after every internal reset pulse. */
`timescale 1ns/1ps
module plw_watchdog_sva (
	input wire logic              clock,
	input wire logic              rst_n,
	input wire plw_pkg::plw_req_t bus_req,
	input wire logic [7:0]        bus_rdata,
	input wire logic              bus_wait,
	input wire logic              fixed_clock_opt,
	input wire logic              wdt_reset
);
	logic seen_reg;
	logic key_wr;
	logic mode_wr;
	assign key_wr = bus_req.wr && !bus_req.bit_op && bus_req.addr == plw_pkg::ADDR_KEY;
	assign mode_wr = bus_req.wr && bus_req.addr == plw_pkg::ADDR_MODE;
	always_ff @(posedge clock) begin
		if (!rst_n)
			seen_reg <= 1'b0;
		else if (mode_wr && !bus_req.bit_op)
			seen_reg <= 1'b1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_KEY_READ: assert property (bus_req.rd && !bus_req.bit_op && bus_req.addr == plw_pkg::ADDR_KEY
		|=> bus_rdata == plw_pkg::KEY_READ) else $error("key read wrong");
	AST_MODE_TOP: assert property (bus_req.rd && bus_req.addr == plw_pkg::ADDR_MODE
		|=> bus_rdata[7:5] == plw_pkg::MODE_TOP_BITS) else $error("mode top bits wrong");
	AST_WAIT_ON: assert property (mode_wr |-> bus_wait) else $error("no wait");
	AST_WAIT_ONLY: assert property (bus_wait |-> mode_wr) else $error("stray wait");
	AST_SECOND: assert property (fixed_clock_opt && seen_reg && mode_wr && !bus_req.bit_op
		|=> wdt_reset) else $error("second mode write no reset");
	AST_BAD_KEY: assert property (fixed_clock_opt && key_wr && bus_req.wdata != plw_pkg::KEY_RESTART
		|=> wdt_reset) else $error("bad key no reset");
	AST_BIT_KEY: assert property (fixed_clock_opt && (bus_req.wr || bus_req.rd) && bus_req.bit_op
		&& bus_req.addr == plw_pkg::ADDR_KEY |=> wdt_reset) else $error("bit key");
	AST_PULSE: assert property (wdt_reset |=> !wdt_reset) else $error("reset too long");
endmodule
bind plw_watchdog plw_watchdog_sva u_sva (.clock, .rst_n, .bus_req, .bus_rdata, .bus_wait,
	.fixed_clock_opt, .wdt_reset);

// ==== bench/plw_cpu.sv ====
/* CPU bus model: one byte or bit access per call.
   Assumes calls come from a single bench process. */
`timescale 1ns/1ps
module plw_cpu (
	input  wire logic         clock,
	output plw_pkg::plw_req_t bus_req
);
	initial bus_req = '0;
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic b);
		@(posedge clock);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: !w, bit_op: b};
		@(posedge clock);
		bus_req <= '0;
	endtask
endmodule

// ==== bench/program_loop_watchdog_test.sv ====
/* Self-checking bench for the program loop watchdog.
   Assumes a plain byte bus and slow tick pins driven here. */
`timescale 1ns/1ps
module program_loop_watchdog_test;
	logic clock = 0, rst_n = 0, fix = 1, halt = 0, stp = 0, osc = 0, x1 = 0;
	logic [7:0] bus_rdata;
	logic bus_wait, wdt_reset;
	plw_pkg::plw_req_t bus_req;
	int n_fail = 0, checks_done = 0, hits = 0;
	always #20 clock = ~clock;
	always @(posedge clock) if (wdt_reset === 1'b1) hits++;
	plw_watchdog u_plw_watchdog (.clock, .rst_n, .bus_req, .bus_rdata, .bus_wait,
		.fixed_clock_opt(fix), .halt_mode(halt), .stop_mode(stp), .internal_osc_clock(osc),
		.x1_clock(x1), .wdt_reset);
	plw_cpu u_plw_cpu (.clock, .bus_req);
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rst;
		@(posedge clock);
		rst_n <= 0;
		repeat (2) @(posedge clock);
		rst_n <= 1;
		hits = 0;
	endtask
	task automatic tick(input int n, input logic sel);
		repeat (n) begin
			@(posedge clock);
			x1 <= sel;
			osc <= !sel;
			repeat (2) @(posedge clock);
			{x1, osc} <= 2'b00;
			@(posedge clock);
		end
	endtask
	// Model: reset pulses seen since last rst against expected count
	task automatic expr(input int e);
		repeat (6) @(posedge clock);
		chk(8'(hits), 8'(e));
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		u_plw_cpu.acc(0, a, 8'h00, 0);
		#1 chk(bus_rdata, e);
	endtask
	initial begin
		void'($urandom(32480));
		rst();
		rd(plw_pkg::ADDR_MODE, plw_pkg::MODE_RESET);
		rd(plw_pkg::ADDR_KEY, plw_pkg::KEY_READ);
		rd(16'hff00, 8'h00);
		stp <= 1;
		halt <= 1;
		u_plw_cpu.acc(1, plw_pkg::ADDR_MODE, 8'h78, 0);
		rd(plw_pkg::ADDR_MODE, 8'h78);
		tick(2047, 0);
		expr(0);
		tick(1, 0);
		expr(1);
		{stp, halt} <= 2'b00;
		rst();
		u_plw_cpu.acc(1, plw_pkg::ADDR_MODE, 8'h60, 0);
		tick(1000 + $urandom_range(1000), 0);
		u_plw_cpu.acc(1, plw_pkg::ADDR_KEY, plw_pkg::KEY_RESTART, 0);
		tick(2047, 0);
		expr(0);
		for (int k = 0; k < 3; k++) begin
			rst();
			u_plw_cpu.acc(1, plw_pkg::ADDR_MODE, 8'h60, 0);
			case (k)
				0: u_plw_cpu.acc(1, plw_pkg::ADDR_MODE, 8'h61, 0);
				1: u_plw_cpu.acc(1, plw_pkg::ADDR_KEY, 8'($urandom_range(171)), 0);
				default: u_plw_cpu.acc(0, plw_pkg::ADDR_KEY, 8'h00, 1);
			endcase
			expr(1);
		end
		fix <= 0;
		rst();
		u_plw_cpu.acc(1, plw_pkg::ADDR_MODE, 8'h70, 0);
		u_plw_cpu.acc(1, plw_pkg::ADDR_KEY, 8'h00, 0);
		u_plw_cpu.acc(1, plw_pkg::ADDR_KEY, 8'h00, 1);
		u_plw_cpu.acc(1, plw_pkg::ADDR_MODE, 8'h60, 0);
		expr(0);
		rst();
		u_plw_cpu.acc(1, plw_pkg::ADDR_MODE, 8'h68, 0);
		tick(300, 0);
		tick(4000, 1);
		halt <= 1;
		tick(200, 1);
		halt <= 0;
		tick(4191, 1);
		expr(0);
		tick(1, 1);
		expr(1);
		report_and_stop();
	end
	initial begin
		#(90000 * 40);
		n_fail++;
		report_and_stop();
	end
endmodule
